// ### msc_codec.sv
// manchester serial codec: transmit encoder, receive decoder, collision path
`timescale 1ns/1ps
module msc_codec (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic ref_clk_20m,
   input  wire logic send_data,
   input  wire logic send_frame_enable,
   input  wire logic idle_zero_sel,
   input  wire logic test_sel,
   input  wire logic rx_line,
   input  wire logic rx_carrier_in,
   input  wire logic collision_in,
   output logic      bit_rate_clock,
   output logic      tx_pos,
   output logic      tx_neg,
   output logic      carrier_present,
   output logic      collision_detect_out,
   output logic      recovered_clock,
   output logic      recovered_data
);
   import msc_pkg::*;

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic [SYNC_W-1:0] sync_in;
   logic [SYNC_W-1:0] sync_meta;
   logic [SYNC_W-1:0] sync_q;

   assign sync_in[SY_RX_LINE]   = rx_line;
   assign sync_in[SY_CARRIER]   = rx_carrier_in;
   assign sync_in[SY_COLL]      = collision_in;
   assign sync_in[SY_REF]       = ref_clk_20m;
   assign sync_in[SY_SEND_DATA] = send_data;
   assign sync_in[SY_SEND_EN]   = send_frame_enable;
   assign sync_in[SY_TEST_SEL]  = test_sel;
   assign sync_in[SY_IDLE_SEL]  = idle_zero_sel;

   // every pin is asynchronous to clk, so each lane gets two stages
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               sync_meta[gi] <= 1'b0;
               sync_q[gi]    <= 1'b0;
            end else begin
               sync_meta[gi] <= sync_in[gi];
               sync_q[gi]    <= sync_meta[gi];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // edge detection on synchronised lanes
   // ---------------------------------------------------------------
   logic ref_prev;
   logic rx_prev;
   logic next_ref_prev;
   logic next_rx_prev;
   logic ref_rise;
   logic rx_rise;
   logic rx_fall;

   always_comb begin
      next_ref_prev = sync_q[SY_REF];
      next_rx_prev  = sync_q[SY_RX_LINE];
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ref_prev <= 1'b0;
         rx_prev  <= 1'b0;
      end else begin
         ref_prev <= next_ref_prev;
         rx_prev  <= next_rx_prev;
      end
   end

   // both lanes reset low, so a line idling high gives one rise after reset;
   // the decoder ignores it because it only counts edges once carrier is up
   always_comb begin
      ref_rise = sync_q[SY_REF] & ~ref_prev;
      rx_rise  = sync_q[SY_RX_LINE] & ~rx_prev;
      rx_fall  = ~sync_q[SY_RX_LINE] & rx_prev;
   end

   // ---------------------------------------------------------------
   // transmit path
   // ---------------------------------------------------------------
   // the reference is oversampled at 125 MHz, so the edges carry up to
   // one clk period of phase error; fine for a drop cable, not for jitter
   // budgets tighter than 8 ns
   msc_encoder u_encoder (
      .clk               (clk),
      .resetn            (resetn),
      .ref_rise          (ref_rise),
      .send_data         (sync_q[SY_SEND_DATA]),
      .send_frame_enable (sync_q[SY_SEND_EN]),
      .idle_zero         (sync_q[SY_IDLE_SEL]),
      .bit_rate_clock    (bit_rate_clock),
      .tx_pos            (tx_pos),
      .tx_neg            (tx_neg)
   );

   // ---------------------------------------------------------------
   // carrier and collision detectors
   // ---------------------------------------------------------------
   msc_glitch_filter #(
      .ON_CYC  (COLL_ON_CYC),
      .OFF_CYC (COLL_OFF_CYC)
   ) u_coll_filter (
      .clk     (clk),
      .resetn  (resetn),
      .sig_in  (sync_q[SY_COLL]),
      .sig_out (collision_detect_out)
   );

   msc_glitch_filter #(
      .ON_CYC  (CARR_ON_CYC),
      .OFF_CYC (CARR_OFF_CYC)
   ) u_carr_filter (
      .clk     (clk),
      .resetn  (resetn),
      .sig_in  (sync_q[SY_CARRIER]),
      .sig_out (carrier_present)
   );

   // ---------------------------------------------------------------
   // decoder state
   // ---------------------------------------------------------------
   // the line is timed from the last accepted mid-cell edge, not from a
   // tracked bit clock: cheap, but two neighbouring mid-cell edges must land
   // more than the blanking window apart and a boundary edge less than it
   msc_dec_state_t state;
   msc_dec_state_t next_state;
   logic [1:0]     falls;
   logic [1:0]     next_falls;
   logic [7:0]     since_edge;
   logic [7:0]     next_since_edge;
   logic           pending;
   logic           next_pending;
   logic           pend_data;
   logic           next_pend_data;
   logic           dec_clk;
   logic           next_dec_clk;
   logic           dec_data;
   logic           next_dec_data;
   logic           edge_ok;
   logic           edge_any;
   logic           edge_late;

   // boundary edges sit half a bit after a mid-cell edge and are blanked
   always_comb begin
      edge_any  = rx_rise | rx_fall;
      edge_late = since_edge >= WIN_CYC - 8'h01;
      edge_ok   = edge_any & edge_late;
   end

   always_comb begin
      next_state      = state;
      next_falls      = falls;
      next_since_edge = since_edge;
      next_pending    = pending;
      next_pend_data  = pend_data;
      next_dec_clk    = dec_clk;
      next_dec_data   = dec_data;

      // age counter saturates so a long quiet line cannot wrap into the window
      if (since_edge != 8'hFF) begin
         next_since_edge = since_edge + 8'h01;
      end

      unique case (state)
         DEC_IDLE: begin
            next_falls   = FALLS_RST;
            next_pending = 1'b0;
            if (carrier_present) begin
               next_state = DEC_ACQ;
            end
         end
         DEC_ACQ: begin
            // alternating preamble: every edge is a mid-cell edge
            if (rx_fall) begin
               next_falls = falls + 2'h1;
               if (falls == 2'h1) begin
                  next_state      = DEC_LOCK;
                  next_since_edge = CNT_RST;
                  next_pending    = 1'b1;
                  next_pend_data  = 1'b0;
               end
            end
         end
         DEC_LOCK: begin
            if (edge_ok) begin
               // rising mid-cell edge carries a one
               next_since_edge = CNT_RST;
               next_pending    = 1'b1;
               next_pend_data  = rx_rise;
            end
            if (pending & (since_edge == QBIT_CYC - 8'h01)) begin
               next_dec_clk  = 1'b1;
               next_dec_data = pend_data;
               next_pending  = edge_ok;
            end else if (since_edge == QBIT_CYC + HALF_CYC - 8'h01) begin
               next_dec_clk = 1'b0;
            end
         end
      endcase

      // carrier loss overrides whatever the state machine chose
      if (!carrier_present) begin
         next_state    = DEC_IDLE;
         next_dec_clk  = RCLK_IDLE;
         next_dec_data = RDATA_IDLE;
         next_pending  = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // decoder registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state      <= DEC_IDLE;
         falls      <= FALLS_RST;
         since_edge <= CNT_RST;
         pending    <= 1'b0;
         pend_data  <= 1'b0;
         dec_clk    <= RCLK_IDLE;
         dec_data   <= RDATA_IDLE;
      end else begin
         state      <= next_state;
         falls      <= next_falls;
         since_edge <= next_since_edge;
         pending    <= next_pending;
         pend_data  <= next_pend_data;
         dec_clk    <= next_dec_clk;
         dec_data   <= next_dec_data;
      end
   end

   // ---------------------------------------------------------------
   // receive outputs and test mode
   // ---------------------------------------------------------------
   logic next_recovered_clock;
   logic next_recovered_data;

   always_comb begin
      next_recovered_clock = dec_clk;
      next_recovered_data  = dec_data;
      // test low trades idle levels for live outputs so thresholds can be probed
      if (!sync_q[SY_TEST_SEL]) begin
         if (state != DEC_LOCK) begin
            next_recovered_data = sync_q[SY_RX_LINE];
            if (carrier_present) begin
               next_recovered_clock = 1'b1;
            end else begin
               next_recovered_clock = bit_rate_clock;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         recovered_clock <= RCLK_IDLE;
         recovered_data  <= RDATA_IDLE;
      end else begin
         recovered_clock <= next_recovered_clock;
         recovered_data  <= next_recovered_data;
      end
   end

endmodule : msc_codec

// ### msc_pkg.sv
// constants shared by the serial codec modules
package msc_pkg;

   // ---------------------------------------------------------------
   // clock
   // ---------------------------------------------------------------
   localparam int CLK_MHZ         = 125;
   localparam int CLK_PERIOD_NS   = 1000 / CLK_MHZ;

   // ---------------------------------------------------------------
   // times in ns
   // ---------------------------------------------------------------
   localparam int BIT_TIME_NS     = 100;
   localparam int QUARTER_BIT_NS  = BIT_TIME_NS / 4;
   localparam int HALF_BIT_NS     = BIT_TIME_NS / 2;
   localparam int EDGE_WINDOW_NS  = (BIT_TIME_NS * 3) / 4;
   localparam int COLL_REJECT_NS  = 10;
   localparam int CARR_REJECT_NS  = 20;
   localparam int CARR_OFF_NS     = 160;
   localparam int COLL_OFF_NS     = 160;

   // ---------------------------------------------------------------
   // derived cycle counts
   // ---------------------------------------------------------------
   // delay after a mid-cell edge before the recovered clock rises (rounded up)
   localparam logic [7:0] QBIT_CYC   = 8'((QUARTER_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // recovered clock high time (rounded down)
   localparam logic [7:0] HALF_CYC   = 8'(HALF_BIT_NS / CLK_PERIOD_NS);
   // blanking after a mid-cell edge, cell boundary edges fall inside it
   localparam logic [7:0] WIN_CYC    = 8'(EDGE_WINDOW_NS / CLK_PERIOD_NS);
   // a burst must outlast the reject time by one sample to count
   localparam logic [7:0] COLL_ON_CYC  =
      8'((COLL_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1);
   localparam logic [7:0] CARR_ON_CYC  =
      8'((CARR_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1);
   localparam logic [7:0] CARR_OFF_CYC = 8'(CARR_OFF_NS / CLK_PERIOD_NS);
   localparam logic [7:0] COLL_OFF_CYC = 8'(COLL_OFF_NS / CLK_PERIOD_NS);

   // ---------------------------------------------------------------
   // reset and idle values
   // ---------------------------------------------------------------
   localparam logic [7:0] CNT_RST    = 8'h00;
   localparam logic [1:0] FALLS_RST  = 2'h0;
   localparam logic       RCLK_IDLE  = 1'b0;
   localparam logic       RDATA_IDLE = 1'b1;

   // ---------------------------------------------------------------
   // synchroniser lanes
   // ---------------------------------------------------------------
   localparam int SYNC_W        = 8;
   localparam int SY_RX_LINE    = 0;
   localparam int SY_CARRIER    = 1;
   localparam int SY_COLL       = 2;
   localparam int SY_REF        = 3;
   localparam int SY_SEND_DATA  = 4;
   localparam int SY_SEND_EN    = 5;
   localparam int SY_TEST_SEL   = 6;
   localparam int SY_IDLE_SEL   = 7;

   typedef enum logic [1:0] {
      DEC_IDLE,
      DEC_ACQ,
      DEC_LOCK
   } msc_dec_state_t;

endpackage : msc_pkg

// ### msc_glitch_filter.sv
// pulse width filter: output follows input after it holds steady long enough
`timescale 1ns/1ps
module msc_glitch_filter #(
   parameter logic [7:0] ON_CYC  = 8'h02,
   parameter logic [7:0] OFF_CYC = 8'h02
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic sig_in,
   output logic      sig_out
);
   import msc_pkg::*;

   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic       next_sig_out;
   logic [7:0] limit;

   always_comb begin
      limit        = sig_out ? OFF_CYC : ON_CYC;
      next_cnt     = CNT_RST;
      next_sig_out = sig_out;
      // any return to the current level restarts the count
      if (sig_in != sig_out) begin
         if (cnt >= limit - 8'h01) begin
            next_sig_out = sig_in;
         end else begin
            next_cnt = cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt     <= CNT_RST;
         sig_out <= 1'b0;
      end else begin
         cnt     <= next_cnt;
         sig_out <= next_sig_out;
      end
   end

endmodule : msc_glitch_filter

// ### msc_encoder.sv
// manchester encoder and bit clock divider
`timescale 1ns/1ps
module msc_encoder (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic ref_rise,
   input  wire logic send_data,
   input  wire logic send_frame_enable,
   input  wire logic idle_zero,
   output logic      bit_rate_clock,
   output logic      tx_pos,
   output logic      tx_neg
);
   import msc_pkg::*;

   logic active;
   logic bit_val;
   logic next_bit_rate_clock;
   logic next_active;
   logic next_bit_val;
   logic next_tx_pos;
   logic next_tx_neg;

   always_comb begin
      next_bit_rate_clock = bit_rate_clock;
      next_active         = active;
      next_bit_val        = bit_val;
      next_tx_pos         = tx_pos;
      next_tx_neg         = tx_neg;
      if (ref_rise) begin
         // one half-cell symbol per reference cycle
         next_bit_rate_clock = ~bit_rate_clock;
         if (!bit_rate_clock) begin
            // rising bit clock: sample the controller and start a cell
            next_active  = send_frame_enable;
            next_bit_val = send_data;
            if (send_frame_enable) begin
               next_tx_pos = ~send_data;
               next_tx_neg = send_data;
            end
         end else if (active) begin
            next_tx_pos = bit_val;
            next_tx_neg = ~bit_val;
         end
         if (!next_active) begin
            // idle: zero differential or positive, chosen by the mode pin
            next_tx_pos = ~idle_zero;
            next_tx_neg = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bit_rate_clock <= 1'b0;
         active         <= 1'b0;
         bit_val        <= 1'b0;
         tx_pos         <= 1'b1;
         tx_neg         <= 1'b0;
      end else begin
         bit_rate_clock <= next_bit_rate_clock;
         active         <= next_active;
         bit_val        <= next_bit_val;
         tx_pos         <= next_tx_pos;
         tx_neg         <= next_tx_neg;
      end
   end

endmodule : msc_encoder

// ### msc_checker.sv
// assertion checker for the manchester serial codec
`timescale 1ns/1ps
module msc_checker (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ref_clk_20m,
   input wire logic send_data,
   input wire logic send_frame_enable,
   input wire logic idle_zero_sel,
   input wire logic test_sel,
   input wire logic rx_line,
   input wire logic rx_carrier_in,
   input wire logic collision_in,
   input wire logic bit_rate_clock,
   input wire logic tx_pos,
   input wire logic tx_neg,
   input wire logic carrier_present,
   input wire logic collision_detect_out,
   input wire logic recovered_clock,
   input wire logic recovered_data
);
   // ------------------------------------------
   // helpers: bit clock period, raw input history
   // ------------------------------------------
   logic [7:0] per;
   logic       brc_q;
   logic       seen;
   logic [7:0] ch;
   logic [7:0] kh;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         per   <= 8'h00;
         brc_q <= 1'b0;
         seen  <= 1'b0;
         ch    <= 8'h00;
         kh    <= 8'h00;
      end else begin
         per   <= (bit_rate_clock && !brc_q) ? 8'h00 : per + 8'h01;
         brc_q <= bit_rate_clock;
         seen  <= seen | (bit_rate_clock & ~brc_q);
         ch    <= {ch[6:0], collision_in};
         kh    <= {kh[6:0], rx_carrier_in};
      end
   end

   // ------------------------------------------
   // assertions
   // ------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // ref sampling jitter: accepts a rise 11 to 15 clks after the previous one, nominal 12.5
   AST_BRC_PERIOD: assert property (
      $rose(bit_rate_clock) && seen |-> per inside {[8'h0A:8'h0E]})
      else $error("bit clock period off");
   AST_TX_FLIP: assert property (
      // with the zero idle a differing pair can only be a frame symbol
      $fell(bit_rate_clock) && ($past(tx_pos) != $past(tx_neg))
      && idle_zero_sel && $past(idle_zero_sel, 16)
      |-> (tx_pos != $past(tx_pos)) && (tx_neg != $past(tx_neg)))
      else $error("no mid-cell reversal");
   AST_TX_STEADY: assert property (
      $changed({tx_pos, tx_neg}) |-> $changed(bit_rate_clock))
      else $error("line output moved off a half-cell boundary");
   AST_COLL_REJECT: assert property (
      $rose(collision_detect_out) |-> $countones(ch) >= 2)
      else $error("collision raised by short burst");
   AST_CARR_REJECT: assert property (
      $rose(carrier_present) |-> $countones(kh) >= 3)
      else $error("carrier raised by short burst");
   AST_COLL_FOLLOW: assert property (
      collision_in [*8] |=> collision_detect_out)
      else $error("collision not reported");
   AST_RX_IDLE: assert property (
      (test_sel && !carrier_present) [*6] |-> !recovered_clock && recovered_data)
      else $error("receive outputs not idle");
   AST_RDATA_SYNC: assert property (
      $changed(recovered_data) && carrier_present && $past(carrier_present)
      && test_sel && $past(test_sel, 8) |-> $rose(recovered_clock))
      else $error("data moved without clock rise");
   // four bit times from preamble start, carrier itself takes a few clks
   AST_LOCK_TIME: assert property (
      $rose(carrier_present) && test_sel |-> ##[1:52] $rose(recovered_clock))
      else $error("no lock in time");

   cover property ($rose(collision_detect_out));
   cover property ($rose(recovered_clock) && test_sel);
   cover property ($fell(bit_rate_clock) && (tx_pos != tx_neg));
endmodule : msc_checker

bind msc_codec msc_checker msc_checker_inst (
   .clk, .resetn, .ref_clk_20m, .send_data, .send_frame_enable, .idle_zero_sel,
   .test_sel, .rx_line, .rx_carrier_in, .collision_in, .bit_rate_clock, .tx_pos,
   .tx_neg, .carrier_present, .collision_detect_out, .recovered_clock, .recovered_data
);

// ### msc_partner.sv
// far-side model: reference oscillator, controller feed, receiver levels
`timescale 1ns/1ps
module msc_partner (
   input  wire logic clk,
   input  wire logic bit_rate_clock,
   output logic      ref_clk_20m,
   output logic      send_data,
   output logic      send_frame_enable,
   output logic      rx_line,
   output logic      rx_carrier_in,
   output logic      collision_in
);
   initial begin
      ref_clk_20m = 1'b0;
      send_data = 1'b0;
      send_frame_enable = 1'b0;
      rx_line = 1'b1;
      rx_carrier_in = 1'b0;
      collision_in = 1'b0;
   end
   // free running, unrelated in phase to clk
   always #25 ref_clk_20m = ~ref_clk_20m;

   // controller: data changes just after each bit clock rise
   task automatic tx_send(input logic [15:0] b, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge bit_rate_clock);
         @(negedge clk);
         send_frame_enable = 1'b1;
         send_data = b[i];
      end
      @(posedge bit_rate_clock);
      @(negedge clk);
      send_frame_enable = 1'b0;
      send_data = ~send_data;
   endtask : tx_send

   // one received frame; jit delays every other mid-cell edge
   task automatic rx_send(input logic [15:0] b, input int n, input int jit);
      int d;
      rx_carrier_in = 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         d = i[0] ? jit : 0;
         rx_line = ~b[i];
         #(50 + d);
         rx_line = b[i];
         #(50 - d);
      end
      rx_carrier_in = 1'b0;
      #300;
      rx_line = ~rx_line;
   endtask : rx_send

   task automatic pulse(input logic coll, input int ns);
      @(negedge clk);
      if (coll) collision_in = 1'b1;
      else rx_carrier_in = 1'b1;
      #(ns);
      collision_in = 1'b0;
      rx_carrier_in = 1'b0;
   endtask : pulse
endmodule : msc_partner

// ### msc_codec_tb.sv
// self-checking testbench for the manchester serial codec
`timescale 1ns/1ps
module msc_codec_tb;
   logic clk, resetn, idle_zero_sel, test_sel;
   logic ref_clk_20m, send_data, send_frame_enable;
   logic rx_line, rx_carrier_in, collision_in;
   logic bit_rate_clock, tx_pos, tx_neg, carrier_present;
   logic collision_detect_out, recovered_clock, recovered_data;
   logic rq[$];
   int   mismatches;
   int   comparisons;

   msc_codec msc_codec_inst (
      .clk, .resetn, .ref_clk_20m, .send_data, .send_frame_enable, .idle_zero_sel,
      .test_sel, .rx_line, .rx_carrier_in, .collision_in, .bit_rate_clock, .tx_pos,
      .tx_neg, .carrier_present, .collision_detect_out, .recovered_clock, .recovered_data
   );
   msc_partner msc_partner_inst (
      .clk, .bit_rate_clock, .ref_clk_20m, .send_data, .send_frame_enable,
      .rx_line, .rx_carrier_in, .collision_in
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // data is held until the next rise, so the fall is a safe sample point
   always @(negedge recovered_clock) rq.push_back(recovered_data);

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : stop_test

   task automatic t_tx(input logic [7:0] b, input logic iz);
      @(negedge clk);
      idle_zero_sel = iz;
      repeat (20) @(negedge clk);
      chk("tx idle", iz ? 2'h0 : 2'h2, {tx_pos, tx_neg});
      fork
         msc_partner_inst.tx_send({8'h00, b}, 8);
         begin
            @(posedge send_frame_enable);
            for (int i = 7; i >= 0; i--) begin
               @(posedge bit_rate_clock);
               @(negedge clk);
               chk("tx first", {~b[i], b[i]}, {tx_pos, tx_neg});
               @(negedge bit_rate_clock);
               @(negedge clk);
               chk("tx second", {b[i], ~b[i]}, {tx_pos, tx_neg});
            end
            repeat (3) begin
               @(posedge bit_rate_clock);
               @(negedge clk);
               chk("tx after", iz ? 2'h0 : 2'h2, {tx_pos, tx_neg});
            end
         end
      join
      $display("test tx done");
   endtask : t_tx

   task automatic t_rx(input logic [15:0] b, input int jit);
      rq.delete();
      msc_partner_inst.rx_send(b, 16, jit);
      repeat (40) @(negedge clk);
      chk("rx count", 1'b1, rq.size() >= 13);
      for (int i = 0; i < 13; i++)
         if (i < rq.size()) chk("rx bit", b[12 - i], rq[i]);
      chk("rx idle", 2'h1, {recovered_clock, recovered_data});
      $display("test rx done");
   endtask : t_rx

   task automatic burst(input logic coll, input int ns, output logic hi);
      hi = 1'b0;
      fork
         msc_partner_inst.pulse(coll, ns);
         repeat (30) begin
            @(negedge clk);
            hi |= coll ? collision_detect_out : carrier_present;
         end
      join
   endtask : burst

   task automatic t_coll();
      logic h;
      burst(1'b1, 8, h);
      chk("short collision", 1'b0, h);
      burst(1'b0, 16, h);
      chk("short carrier", 1'b0, h);
      burst(1'b1, 40, h);
      chk("collision", 1'b1, h);
      repeat (20) @(negedge clk);
      chk("collision off", 1'b0, collision_detect_out);
      burst(1'b1, 80, h);
      chk("long collision", 1'b1, h);
      $display("test collision done");
   endtask : t_coll

   task automatic t_test();
      logic hi;
      logic lo;
      @(negedge clk);
      test_sel = 1'b0;
      repeat (10) @(negedge clk);
      for (int v = 0; v < 2; v++) begin
         msc_partner_inst.rx_line = v[0];
         repeat (6) @(negedge clk);
         chk("test data", v[0], recovered_data);
      end
      {hi, lo} = 2'h0;
      repeat (30) begin
         @(negedge clk);
         hi |= recovered_clock;
         lo |= ~recovered_clock;
      end
      chk("test clock runs", 2'h3, {hi, lo});
      fork
         msc_partner_inst.pulse(1'b0, 200);
         begin
            repeat (15) @(negedge clk);
            chk("carrier on", 1'b1, carrier_present);
            chk("acquire clock", 1'b1, recovered_clock);
         end
      join
      repeat (40) @(negedge clk);
      chk("carrier off", 1'b0, carrier_present);
      test_sel = 1'b1;
      repeat (10) @(negedge clk);
      $display("test mode done");
   endtask : t_test

   initial begin
      mismatches = 0;
      comparisons = 0;
      resetn = 1'b0;
      idle_zero_sel = 1'b0;
      test_sel = 1'b1;
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      repeat (10) @(negedge clk);
      t_tx(8'hB2, 1'b1);
      t_tx(8'h4D, 1'b0);
      t_rx(16'hAA33, 0);
      t_rx(16'hAAE4, 19);
      t_coll();
      t_test();
      stop_test();
   end

   // whole run is some 1,200 clks
   initial begin
      #100000;
      mismatches++;
      $display("MISMATCH watchdog expected done seen hang");
      stop_test();
   end
endmodule : msc_codec_tb
